/* File: phy_mgmt_pkg.sv */
package phy_mgmt_pkg;
  // Clock and time base
  localparam int CLK_KHZ = 20000;
  localparam int TICK_US = 25000;
  localparam int TICK_CYCLES_DFLT = TICK_US * CLK_KHZ / 1000;
  // Stretch length in ms per rate code; the blink period has the same figure
  localparam int RATE_MS [4] = '{400, 200, 100, 50};
  // Widths
  localparam int FUNC_W = 4;
  localparam int EVT_W = 8;
  localparam int HOLD_W = 5;
  localparam int TICK_W = 24;
  // Management register indices
  localparam logic [4:0] REG_LED_FUNC = 5'h16;
  localparam logic [4:0] REG_LED_BEH = 5'h17;
  localparam logic [4:0] REG_MDIO_DRV = 5'h19;
  localparam logic [4:0] REG_SCHEME = 5'h1a;
  localparam logic [4:0] REG_INT_CTL = 5'h1b;
  localparam logic [4:0] REG_CONTROL = 5'h1f;
  // Field positions
  localparam int FUNC_ONE_LO = 0;
  localparam int FUNC_TWO_LO = 4;
  localparam int BEH_ACT_SEL = 14;
  localparam int BEH_PULSE = 12;
  localparam int BEH_RATE_LO = 10;
  localparam int BEH_STRETCH_LO = 5;
  localparam int BEH_COMBO_LO = 0;
  localparam int DRV_PUSH_BIT = 1;
  localparam int SCHEME_LEGACY_BIT = 14;
  localparam int CTL_POL_BIT = 14;
  localparam int INT_EN_LO = 8;
  // Reset values
  localparam logic [3:0] FUNC_ONE_RST = 4'h1;
  localparam logic [3:0] FUNC_TWO_RST = 4'h2;
  localparam logic PULSE_RST = 1'b1;
  localparam logic LEGACY_RST = 1'b1;
  // Serial frame fields
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] HEADER_BITS = 6'h0c;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [5:0] SKIP_BITS = 6'h12;

  // Tick count for a rate code: full length when stretching, half period for blink
  function automatic logic [HOLD_W-1:0] rate_ticks(input logic [1:0] rate, input logic full);
    int us;
    us = RATE_MS[rate] * 1000;
    return full ? HOLD_W'(us / TICK_US) : HOLD_W'(us / (2 * TICK_US));
  endfunction
endpackage

/* File: mdio_serial_port.sv */
`timescale 1ns/1ns
`default_nettype none
module mdio_serial_port (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_mdc,
  input wire logic i_mdio_in,
  input wire logic [4:0] i_phy_addr,
  input wire logic i_push_pull,
  input wire logic [15:0] i_rd_data,
  output logic o_mdio_out,
  output logic o_mdio_oe,
  output logic o_rd_stb,
  output logic o_wr_stb,
  output logic [4:0] o_reg_addr,
  output logic [15:0] o_wr_data
);
  import phy_mgmt_pkg::*;

  typedef enum logic [2:0] {st_pre, st_start, st_hdr, st_ta, st_rd, st_ta_w, st_wr, st_skip} frame_t;

  frame_t state;
  logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
  logic [11:0] hdr;
  logic [15:0] dat;
  logic [5:0] cnt;
  logic drv_en, drv_bit;

  // Two-stage synchronisers, then edge finder on the second stage
  always_ff @(posedge i_mclk) begin
    mdc_s1 <= i_mdc;
    mdc_s2 <= mdc_s1;
    mdc_s3 <= mdc_s2;
    mdio_s1 <= i_mdio_in;
    mdio_s2 <= mdio_s1;
  end

  wire rise = mdc_s2 & ~mdc_s3;
  wire bit_in = mdio_s2;
  wire [11:0] next_hdr = {hdr[10:0], bit_in};
  wire addr_hit = next_hdr[9:5] == i_phy_addr;
  wire hdr_done = cnt == HEADER_BITS - 6'h01;

  // Frame sequencer; sampling and driving both follow the clock's rising edge
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= st_pre;
      cnt <= '0;
      hdr <= '0;
      dat <= '0;
      drv_en <= 1'b0;
      drv_bit <= 1'b1;
      o_rd_stb <= 1'b0;
      o_wr_stb <= 1'b0;
    end else begin
      o_rd_stb <= 1'b0;
      o_wr_stb <= 1'b0;
      if (o_rd_stb) begin
        dat <= i_rd_data;
      end
      if (rise) begin
        case (state)
          st_pre: begin
            if (bit_in) begin
              cnt <= (cnt == PREAMBLE_BITS) ? cnt : cnt + 6'h01;
            end else if (cnt == PREAMBLE_BITS) begin
              state <= st_start;
            end else begin
              cnt <= '0;
            end
          end
          st_start: begin
            cnt <= '0;
            state <= bit_in ? st_hdr : st_pre;
          end
          st_hdr: begin
            hdr <= next_hdr;
            cnt <= hdr_done ? 6'h00 : cnt + 6'h01;
            if (hdr_done) begin
              if (addr_hit && next_hdr[11:10] == OP_READ) begin
                state <= st_ta;
                o_rd_stb <= 1'b1;
              end else if (addr_hit && next_hdr[11:10] == OP_WRITE) begin
                state <= st_ta_w;
              end else begin
                state <= st_skip;
              end
            end
          end
          st_ta: begin
            drv_en <= 1'b1; // Second turnaround bit driven low
            drv_bit <= 1'b0;
            state <= st_rd;
          end
          st_rd: begin
            if (cnt == DATA_BITS) begin
              drv_en <= 1'b0;
              drv_bit <= 1'b1;
              cnt <= '0;
              state <= st_pre;
            end else begin
              drv_bit <= dat[15];
              dat <= {dat[14:0], 1'b0};
              cnt <= cnt + 6'h01;
            end
          end
          st_ta_w: begin
            cnt <= (cnt == 6'h01) ? 6'h00 : cnt + 6'h01;
            state <= (cnt == 6'h01) ? st_wr : st_ta_w;
          end
          st_wr: begin
            dat <= {dat[14:0], bit_in};
            cnt <= cnt + 6'h01;
            if (cnt == DATA_BITS - 6'h01) begin
              o_wr_stb <= 1'b1;
              cnt <= '0;
              state <= st_pre;
            end
          end
          st_skip: begin
            cnt <= cnt + 6'h01;
            if (cnt == SKIP_BITS - 6'h01) begin
              cnt <= '0;
              state <= st_pre;
            end
          end
          default: state <= st_pre;
        endcase
      end
    end
  end

  // Open-drain only pulls low; push-pull drives both levels
  assign o_mdio_oe = drv_en & (i_push_pull | ~drv_bit);
  assign o_mdio_out = drv_bit & i_push_pull;
  assign o_reg_addr = hdr[4:0];
  assign o_wr_data = dat;

  a_open_drain_release: assert property (@(posedge i_mclk) disable iff (i_rst)
    (drv_en && drv_bit && !i_push_pull) |-> !o_mdio_oe)
    else $error("open-drain output drove a high level");
  a_push_pull_drive: assert property (@(posedge i_mclk) disable iff (i_rst)
    (drv_en && i_push_pull) |-> (o_mdio_oe && o_mdio_out == drv_bit))
    else $error("push-pull output not driving data");
endmodule
`default_nettype wire

/* File: phy_led_irq_mdio_regs.sv */
// Notes on behaviour
// - Index 22 holds indicator function codes, used only in extended mode.
// - Bits 7:4 of index 22 are indicator_two function, read/write, reset 0010.
// - Bits 3:0 of index 22 are indicator_one function, read/write, reset 0001.
// - Index 23 holds indicator behaviour, used only in extended mode.
// - Index 23 bit 14 activity select resets 0; bit 12 pulsing enable resets 1.
// - Bits 11:10 pick rate: 2.5/5/10/20 Hz blink or 400/200/100/50 ms.
// - Bits 6 and 5 pick stretch (1) or blink (0) per indicator, reset 0.
// - Bits 1 and 0 clear merge activity or collision; set shows plain state.
// - Index 25 bit 1 selects open-drain (0) or push-pull (1) data output.
// - Index 26 bit 14 selects legacy scheme (1) or extended (0), reset 1.
// - Index 27 bits 15:8 are read/write interrupt enables, reset 0.
// - Index 27 bits 7:0 are matching event flags, clear on read, reset 0.
// - Flag 0 reports link up and flag 2 link down, both clear on read.
// - Flag 1 reports remote fault and flag 4 parallel detect fault.
// - Index 31 bit 14 inverts the interrupt pin sense, reset 0.
`timescale 1ns/1ns
`default_nettype none
module phy_led_irq_mdio_regs #(
  parameter int TICK_CYCLES = phy_mgmt_pkg::TICK_CYCLES_DFLT
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_mdc,
  input wire logic i_mdio_in,
  output logic o_mdio_out,
  output logic o_mdio_oe,
  input wire logic [4:0] i_phy_addr,
  input wire logic [phy_mgmt_pkg::EVT_W-1:0] i_irq_event,
  input wire logic i_link_up,
  input wire logic i_duplex_full,
  input wire logic i_rx_activity,
  input wire logic i_tx_activity,
  input wire logic i_collision,
  output logic o_int_pin,
  output logic o_indicator_one,
  output logic o_indicator_two,
  output logic [phy_mgmt_pkg::FUNC_W-1:0] o_indicator_one_func,
  output logic [phy_mgmt_pkg::FUNC_W-1:0] o_indicator_two_func
);
  import phy_mgmt_pkg::*;

  logic [4:0] addr_s1, addr_s2;
  logic rd_stb, wr_stb;
  logic [4:0] reg_addr;
  logic [15:0] wr_data, rd_data;
  logic [FUNC_W-1:0] func_one, func_two;
  logic act_sel, pulse_en, push_pull, legacy, pol;
  logic [1:0] rate, stretch_sel, combo_dis;
  logic [EVT_W-1:0] irq_en, flags;
  logic [TICK_W-1:0] tick_cnt;
  logic [HOLD_W-1:0] blink_cnt;
  logic [HOLD_W-1:0] hold [2];
  logic phase;

  // Address strap pins come from outside the clock domain
  always_ff @(posedge i_mclk) begin
    addr_s1 <= i_phy_addr;
    addr_s2 <= addr_s1;
  end

  mdio_serial_port u_port (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_mdc(i_mdc),
    .i_mdio_in(i_mdio_in),
    .i_phy_addr(addr_s2),
    .i_push_pull(push_pull),
    .i_rd_data(rd_data),
    .o_mdio_out(o_mdio_out),
    .o_mdio_oe(o_mdio_oe),
    .o_rd_stb(rd_stb),
    .o_wr_stb(wr_stb),
    .o_reg_addr(reg_addr),
    .o_wr_data(wr_data)
  );

  // Register decode
  wire wr_func = wr_stb && reg_addr == REG_LED_FUNC;
  wire wr_beh = wr_stb && reg_addr == REG_LED_BEH;
  wire wr_drv = wr_stb && reg_addr == REG_MDIO_DRV;
  wire wr_scheme = wr_stb && reg_addr == REG_SCHEME;
  wire wr_int = wr_stb && reg_addr == REG_INT_CTL;
  wire wr_ctl = wr_stb && reg_addr == REG_CONTROL;
  wire int_read = rd_stb && reg_addr == REG_INT_CTL;

  // Read data images; reserved bits read as zero
  wire [15:0] rd_func = {8'h00, func_two, func_one};
  wire [15:0] rd_beh = {1'b0, act_sel, 1'b0, pulse_en, rate, 3'h0, stretch_sel, 3'h0, combo_dis};
  wire [15:0] rd_drv = {14'h0000, push_pull, 1'b0};
  wire [15:0] rd_scheme = {1'b0, legacy, 14'h0000};
  wire [15:0] rd_int = {irq_en, flags};
  wire [15:0] rd_ctl = {1'b0, pol, 14'h0000};
  assign rd_data = (reg_addr == REG_LED_FUNC) ? rd_func :
                   (reg_addr == REG_LED_BEH) ? rd_beh :
                   (reg_addr == REG_MDIO_DRV) ? rd_drv :
                   (reg_addr == REG_SCHEME) ? rd_scheme :
                   (reg_addr == REG_INT_CTL) ? rd_int :
                   (reg_addr == REG_CONTROL) ? rd_ctl : 16'h0000;

  // Configuration registers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      func_one <= FUNC_ONE_RST;
      func_two <= FUNC_TWO_RST;
      act_sel <= 1'b0;
      pulse_en <= PULSE_RST;
      rate <= 2'h0;
      stretch_sel <= 2'h0;
      combo_dis <= 2'h0;
      push_pull <= 1'b0;
      legacy <= LEGACY_RST;
      irq_en <= '0;
      pol <= 1'b0;
    end else begin
      if (wr_func) begin
        func_one <= wr_data[FUNC_ONE_LO +: FUNC_W];
        func_two <= wr_data[FUNC_TWO_LO +: FUNC_W];
      end
      if (wr_beh) begin
        act_sel <= wr_data[BEH_ACT_SEL];
        pulse_en <= wr_data[BEH_PULSE];
        rate <= wr_data[BEH_RATE_LO +: 2];
        stretch_sel <= wr_data[BEH_STRETCH_LO +: 2];
        combo_dis <= wr_data[BEH_COMBO_LO +: 2];
      end
      if (wr_drv) begin
        push_pull <= wr_data[DRV_PUSH_BIT];
      end
      if (wr_scheme) begin
        legacy <= wr_data[SCHEME_LEGACY_BIT];
      end
      if (wr_int) begin
        irq_en <= wr_data[INT_EN_LO +: EVT_W];
      end
      if (wr_ctl) begin
        pol <= wr_data[CTL_POL_BIT];
      end
    end
  end

  // Event flags: a read clears what it returned, a new event always sets
  wire [EVT_W-1:0] clr_mask = int_read ? flags : '0;
  wire [EVT_W-1:0] next_flags = (flags & ~clr_mask) | i_irq_event;
  wire irq_active = |(flags & irq_en);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      flags <= '0;
      o_int_pin <= 1'b1;
    end else begin
      flags <= next_flags;
      o_int_pin <= irq_active ? pol : ~pol;
    end
  end

  // Behaviour in force: legacy scheme falls back to reset settings
  wire eff_pulse = legacy ? PULSE_RST : pulse_en;
  wire eff_act_sel = legacy ? 1'b0 : act_sel;
  wire [1:0] eff_rate = legacy ? 2'h0 : rate;
  wire [1:0] eff_stretch = legacy ? 2'h0 : stretch_sel;
  wire [1:0] eff_combo = legacy ? 2'h0 : combo_dis;
  wire [HOLD_W-1:0] stretch_len = rate_ticks(eff_rate, 1'b1);
  wire [HOLD_W-1:0] blink_half = rate_ticks(eff_rate, 1'b0);

  // Activity select set limits activity to receive traffic
  wire [1:0] act = {i_collision, i_rx_activity | (i_tx_activity & ~eff_act_sel)};
  wire [1:0] base = {i_duplex_full, i_link_up};
  wire tick = tick_cnt == TICK_W'(TICK_CYCLES - 1);

  // Time base, blink phase and activity windows
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tick_cnt <= '0;
      blink_cnt <= '0;
      phase <= 1'b0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + TICK_W'(1);
      if (tick) begin
        blink_cnt <= (blink_cnt >= blink_half - HOLD_W'(1)) ? '0 : blink_cnt + HOLD_W'(1);
        phase <= (blink_cnt >= blink_half - HOLD_W'(1)) ? ~phase : phase;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    for (int k = 0; k < 2; k++) begin
      if (i_rst) begin
        hold[k] <= '0;
      end else if (act[k]) begin
        hold[k] <= stretch_len;
      end else if (tick && hold[k] != '0) begin
        hold[k] <= hold[k] - HOLD_W'(1);
      end
    end
  end

  // Activity effect: raw when pulsing is off, else stretched or blinking
  wire [1:0] busy = {hold[1] != '0, hold[0] != '0};
  wire [1:0] effect = !eff_pulse ? act : (eff_stretch & busy) | (~eff_stretch & busy & {2{phase}});
  wire [1:0] next_led = (eff_combo & base) | (~eff_combo & base & ~effect);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_indicator_one <= 1'b0;
      o_indicator_two <= 1'b0;
      o_indicator_one_func <= FUNC_ONE_RST;
      o_indicator_two_func <= FUNC_TWO_RST;
    end else begin
      o_indicator_one <= next_led[0];
      o_indicator_two <= next_led[1];
      o_indicator_one_func <= legacy ? FUNC_ONE_RST : func_one;
      o_indicator_two_func <= legacy ? FUNC_TWO_RST : func_two;
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_int_read;
    rd_stb && reg_addr == REG_INT_CTL;
  endsequence

  a_reset_defaults: assert property ($fell(i_rst) |->
    func_two == FUNC_TWO_RST && func_one == FUNC_ONE_RST && pulse_en && !act_sel
    && legacy && !push_pull && !pol && irq_en == '0 && flags == '0)
    else $error("register reset values wrong");
  a_func_write: assert property (wr_func |=> func_two == $past(wr_data[7:4])
    && func_one == $past(wr_data[3:0]))
    else $error("function code write lost");
  a_legacy_func: assert property (legacy |=> o_indicator_one_func == FUNC_ONE_RST
    && o_indicator_two_func == FUNC_TWO_RST)
    else $error("legacy scheme did not override function codes");
  a_link_down_read: assert property ((s_int_read and flags[2] && !i_irq_event[2])
    |-> rd_data[2] ##1 !flags[2])
    else $error("link down flag not returned and cleared");
  a_late_event_kept: assert property ((s_int_read and i_irq_event[4]) |=> flags[4])
    else $error("event during read was lost");
  a_flag_sticks: assert property ((flags[1] && !int_read) |=> flags[1])
    else $error("flag dropped without a read");
  a_irq_assert: assert property ((i_irq_event[0] && irq_en[0] && !wr_stb)
    ##1 (!int_read && !wr_stb) |=> o_int_pin == pol)
    else $error("interrupt pin not asserted");
  a_irq_idle: assert property ((!irq_active && !wr_ctl) |=> o_int_pin == !pol)
    else $error("interrupt pin active with no enabled flag");
  a_stretch_load: assert property (act[0] |=> hold[0] == $past(stretch_len))
    else $error("stretch window not loaded");
  a_stretch_dark: assert property ((eff_pulse && eff_stretch[0] && !eff_combo[0]
    && hold[0] != '0) |=> !o_indicator_one)
    else $error("stretched activity not shown");
  a_combo_off: assert property (eff_combo[0] |=> o_indicator_one == $past(i_link_up))
    else $error("indicator not showing plain link");
endmodule
`default_nettype wire

/* File: mdio_master.sv */
`timescale 1ns/1ns
`default_nettype none
module mdio_master (
  input wire logic i_mclk,
  input wire logic i_mdio_wire,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_oe
);
  // Clock stands low and data released between frames
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_oe = 1'b0;
  end

  // One whole frame of 64 bits; data changes while the clock is low, read bits are taken at its rise
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(posedge i_mclk);
      o_mdc <= 1'b0;
      o_oe <= (op == phy_mgmt_pkg::OP_WRITE) || (i > 17); // Read hands the line over at turnaround
      o_mdio <= bits[i];
      repeat (4) @(posedge i_mclk);
      o_mdc <= 1'b1;
      if (i < 16) begin
        rd[i] = i_mdio_wire;
      end
      repeat (3) @(posedge i_mclk);
    end
    @(posedge i_mclk);
    o_mdc <= 1'b0;
    o_oe <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import phy_mgmt_pkg::*;
  localparam logic [4:0] PHY = 5'h03;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] evt = 8'h00;
  logic link_up = 1'b1;
  logic duplex = 1'b1;
  logic rx_act = 1'b0;
  logic tx_act = 1'b0;
  logic coll = 1'b0;
  logic mdio_out, mdio_oe, int_pin, ind_one, ind_two;
  logic [3:0] func_one, func_two;
  logic mdc, m_mdio, m_oe;
  logic seen_push = 1'b0;
  logic [15:0] rdv;
  int err_count = 0;
  int checks = 0;
  int lit = 0;
  // Wire level: device drive first, then controller, else the pull-up
  wire mdio_wire = mdio_oe ? mdio_out : (m_oe ? m_mdio : 1'b1);

  always #25 mclk = ~mclk;

  // Notes any cycle where the device drives a one
  always @(posedge mclk) begin
    if (mdio_oe === 1'b1 && mdio_out === 1'b1) begin
      seen_push <= 1'b1;
    end
  end

  mdio_master i_master (.i_mclk(mclk), .i_mdio_wire(mdio_wire), .o_mdc(mdc), .o_mdio(m_mdio), .o_oe(m_oe));

  phy_led_irq_mdio_regs #(.TICK_CYCLES(4)) i_dut (
    .i_mclk(mclk), .i_rst(rst), .i_mdc(mdc), .i_mdio_in(mdio_wire), .o_mdio_out(mdio_out),
    .o_mdio_oe(mdio_oe), .i_phy_addr(PHY), .i_irq_event(evt), .i_link_up(link_up),
    .i_duplex_full(duplex), .i_rx_activity(rx_act), .i_tx_activity(tx_act), .i_collision(coll),
    .o_int_pin(int_pin), .o_indicator_one(ind_one), .o_indicator_two(ind_two),
    .o_indicator_one_func(func_one), .o_indicator_two_func(func_two));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] rd;
    i_master.frame(OP_WRITE, PHY, ra, wd, rd);
    repeat (4) @(posedge mclk);
  endtask

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] rd;
    i_master.frame(OP_READ, PHY, ra, 16'h0000, rd);
    check(rd, exp);
  endtask

  task automatic pulse_evt(input logic [7:0] e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= 8'h00;
  endtask

  // Write table: address, value written, value read back
  logic [4:0] wa [6] = '{REG_LED_FUNC, REG_LED_BEH, REG_MDIO_DRV, REG_INT_CTL, 5'h1c, REG_SCHEME};
  logic [15:0] wv [6] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
  logic [15:0] rv [6] = '{16'h00ff, 16'h5c63, 16'h0002, 16'hff00, 16'h0000, 16'h4000};

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    rd_chk(REG_LED_FUNC, 16'h0021);
    rd_chk(REG_LED_BEH, 16'h1000);
    rd_chk(REG_MDIO_DRV, 16'h0000);
    rd_chk(REG_SCHEME, 16'h4000);
    rd_chk(REG_INT_CTL, 16'h0000);
    rd_chk(REG_CONTROL, 16'h0000);
    check(16'(int_pin), 16'h0001);
    check(16'(seen_push), 16'h0000);
    // Access kinds, reserved bits and an unmapped index
    for (int k = 0; k < 6; k++) begin
      wr(wa[k], wv[k]);
      rd_chk(wa[k], rv[k]);
    end
    check(16'(seen_push), 16'h0001);
    check(16'({func_two, func_one}), 16'h0021);
    // Frame to another station address is ignored
    i_master.frame(OP_WRITE, PHY ^ 5'h01, REG_LED_FUNC, 16'h0035, rdv);
    rd_chk(REG_LED_FUNC, 16'h00ff);
    wr(REG_LED_FUNC, 16'h0035);
    check(16'({func_two, func_one}), 16'h0021);
    wr(REG_SCHEME, 16'h0000);
    check(16'({func_two, func_one}), 16'h0035);
    wr(REG_SCHEME, 16'h4000);
    check(16'({func_two, func_one}), 16'h0021);
    // Interrupt flags, enables and pin
    wr(REG_INT_CTL, 16'h0100);
    pulse_evt(8'h05);
    repeat (2) @(posedge mclk);
    check(16'(int_pin), 16'h0000);
    rd_chk(REG_INT_CTL, 16'h0105);
    check(16'(int_pin), 16'h0001);
    rd_chk(REG_INT_CTL, 16'h0100);
    wr(REG_INT_CTL, 16'h1200);
    pulse_evt(8'h12);
    wr(REG_CONTROL, 16'h4000);
    check(16'(int_pin), 16'h0001);
    rd_chk(REG_CONTROL, 16'h4000);
    rd_chk(REG_INT_CTL, 16'h1212);
    check(16'(int_pin), 16'h0000);
    // Event arriving in the very cycle the read takes its snapshot and clears
    fork
      rd_chk(REG_INT_CTL, 16'h1200);
      begin
        repeat (367) @(posedge mclk);
        pulse_evt(8'h10);
      end
    join
    rd_chk(REG_INT_CTL, 16'h1210);
    // Indicators in extended mode
    wr(REG_SCHEME, 16'h0000);
    wr(REG_LED_BEH, 16'h0003);
    @(posedge mclk);
    rx_act <= 1'b1;
    coll <= 1'b1;
    @(posedge mclk);
    rx_act <= 1'b0;
    coll <= 1'b0;
    repeat (2) @(posedge mclk);
    check(16'({ind_two, ind_one}), 16'h0003);
    // Stretch window length for each rate code
    for (int r = 0; r < 4; r++) begin
      wr(REG_LED_BEH, 16'h1060 | (16'(r) << 10));
      @(posedge mclk);
      rx_act <= 1'b1;
      coll <= 1'b1;
      @(posedge mclk);
      rx_act <= 1'b0;
      coll <= 1'b0;
      repeat (4 * (16 >> r) - 6) @(posedge mclk);
      check(16'({ind_two, ind_one}), 16'h0000);
      repeat (10) @(posedge mclk);
      check(16'({ind_two, ind_one}), 16'h0003);
    end
    // Receive-only activity select ignores transmit
    wr(REG_LED_BEH, 16'h5c60);
    @(posedge mclk);
    tx_act <= 1'b1;
    @(posedge mclk);
    tx_act <= 1'b0;
    repeat (2) @(posedge mclk);
    check(16'(ind_one), 16'h0001);
    // Pulsing off shows raw activity
    wr(REG_LED_BEH, 16'h0000);
    @(posedge mclk);
    rx_act <= 1'b1;
    repeat (3) @(posedge mclk);
    check(16'(ind_one), 16'h0000);
    rx_act <= 1'b0;
    repeat (3) @(posedge mclk);
    check(16'(ind_one), 16'h0001);
    // Blink at the fastest rate: lit for half of any 16 cycles of steady activity
    wr(REG_LED_BEH, 16'h1c00);
    @(posedge mclk);
    rx_act <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int c = 0; c < 16; c++) begin
      @(negedge mclk);
      lit += int'(ind_one);
    end
    @(posedge mclk);
    rx_act <= 1'b0;
    check(16'(lit), 16'h0008);
    complete_run();
  end

  // Hang guard, nearly four times the expected run
  initial begin
    #4000000;
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
